// [shared/mem_write_switch_pkg.sv]
// constants and carrier types for the memory write-cycle switch
// assumes one 25 MHz clock; all pin levels arrive as documented (low-true where named _n)
package mem_write_switch_pkg;

  // ****************************************************************
  // widths and clock
  // ****************************************************************
  localparam int unsigned WORD_W   = 64;
  localparam int unsigned BYTES    = 8;
  localparam int unsigned CNT_W    = 8;
  localparam int unsigned CLK_MHZ  = 25;

  // outer half: bits 00-07 and 40-63, inner half: bits 08-39
  localparam logic [63:0] OUTER_MASK = 64'hffff_ff00_0000_00ff;
  localparam logic [63:0] INNER_MASK = 64'h0000_00ff_ffff_ff00;

  // ****************************************************************
  // timing, in ns and in cycles (least times round up)
  // ****************************************************************
  localparam int unsigned T_WRITE_INIT_NS = 75;
  localparam int unsigned T_CAPTURE_NS    = 40;
  localparam int unsigned T_ENABLE_NS     = 100;
  localparam int unsigned T_CYCLE_NS      = 400;
  localparam int unsigned WRITE_INIT_CYC  = (T_WRITE_INIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CAPTURE_CYC     = (T_CAPTURE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned ENABLE_CYC      = (T_ENABLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CYCLE_CYC       = (T_CYCLE_NS * CLK_MHZ + 999) / 1000;

  // ****************************************************************
  // register port
  // ****************************************************************
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned CTRL_CLEAR_BIT  = 1;
  localparam logic        CTRL_ENABLE_RST = 1'b1;

  // logical route codes {a, b}, a 1 being the low pin level
  localparam logic [1:0] ROUTE_CU = 2'b00;
  localparam logic [1:0] ROUTE_CB = 2'b01;
  localparam logic [1:0] ROUTE_IO = 2'b10;
  localparam logic [1:0] ROUTE_PE = 2'b11;

  typedef enum logic [1:0] {SRC_NONE, SRC_CU, SRC_IO, SRC_PE} write_source_t;

  // control pins from the element / control unit, at pin level
  typedef struct packed {
    logic       cycle_initiate_in;
    logic       memory_select_in;
    logic       read_write_select_n;
    logic       route_select_a_n;
    logic       route_select_b_n;
    logic       outer_half_sel_n;
    logic       inner_half_sel_n;
    logic       low_region_protect_n;
    logic       protect_error_clear_n;
    logic [3:0] address_hi_n;
  } ctrl_pins_t;

  // everything that goes to the element memory
  typedef struct packed {
    logic        memory_go_pulse_n;
    logic        outer_half_write_en;
    logic        inner_half_write_en;
    logic [63:0] write_word;
  } mem_out_t;

endpackage : mem_write_switch_pkg

// [verilog/memory_write_cycle_switch.sv]
// write-cycle data switch in front of the element memory
// assumes control and data pins are asynchronous to ref_clk and held through the cycle;
// transfer_active comes from the transfer path on the same clock
// What this block does
// - memory go on writes only with permit set, transfer clear, delayed initiate arrived
// - write permit rests set; a protect violation clears it, blocking that go
// - delayed write initiate follows the timing initiate by about 75 ns
// - the extra initiate delay applies to writes only; reads go at once
// - memory go leaves the block inverted, as a low-true pulse
// - outer enable stores bits 00-07 and 40-63, inner enable bits 08-39
// - both enables together write the whole 64-bit word
// - on element writes a low half-select pin sets its half latch
// - outer latch governs outer enable, inner latch inner enable on element writes
// - control unit or I/O source forces both enables true
// - route code: write 00 cu, 10 io, 11 element; read 01 cb, 10, 11
// - control-unit data takes the same path as element data
// - I/O data goes to the select gates ungated
// - 64 select gates feed the holding latches, each inverting its bit
// - I/O select only for I/O route, write cycle, transfer clear
// - element data gated per half: element select AND that half latch
// - a strobe per byte slice captures the selected data shortly after
// - holding-latch outputs are inverted again so memory stores true data
// - timing initiate comes from memory select and cycle initiate together
// - protect on and address bits 05-08 false: inhibit enables, set error latch
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none

module memory_write_cycle_switch
  import mem_write_switch_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire ctrl_pins_t        ctrl_pins,
  input  wire logic [63:0]       element_write_bits,
  input  wire logic [63:0]       io_write_bits,
  input  wire logic              transfer_active,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_write,
  input  wire logic              reg_read,
  output logic      [31:0]       reg_rdata,
  output mem_out_t               mem_out,
  output logic                   timing_initiate_pulse,
  output logic                   delayed_write_go,
  output logic                   io_write_select,
  output logic                   element_write_select,
  output logic [7:0]             capture_strobe_pulse,
  output logic                   protect_error
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  // initiate pins rest low and low-true pins high, so no cycle starts as reset ends
  localparam ctrl_pins_t PINS_IDLE = '{cycle_initiate_in: 1'b0, memory_select_in: 1'b0,
                                       address_hi_n: 4'hf, default: 1'b1};
  ctrl_pins_t  pins_meta;
  ctrl_pins_t  pins;
  logic [63:0] elem_meta;
  logic [63:0] elem_bits;
  logic [63:0] io_meta;
  logic [63:0] io_bits;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pins_meta <= PINS_IDLE;
      pins      <= PINS_IDLE;
      elem_meta <= '0;
      elem_bits <= '0;
      io_meta   <= '0;
      io_bits   <= '0;
    end else begin
      pins_meta <= ctrl_pins;
      pins      <= pins_meta;
      elem_meta <= element_write_bits;
      elem_bits <= elem_meta;
      io_meta   <= io_write_bits;
      io_bits   <= io_meta;
    end
  end

  // ****************************************************************
  // register port
  // ****************************************************************
  logic switch_enable;
  logic sw_clear;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      switch_enable <= CTRL_ENABLE_RST;
    end else if (reg_write && reg_addr == ADDR_CTRL) begin
      switch_enable <= reg_wdata[CTRL_ENABLE_BIT];
    end
  end

  assign sw_clear = reg_write && reg_addr == ADDR_CTRL && reg_wdata[CTRL_CLEAR_BIT];

  // ****************************************************************
  // cycle sequencer
  // ****************************************************************
  typedef enum logic {ST_IDLE, ST_ACTIVE} seq_state_t;

  seq_state_t       state;
  logic [CNT_W-1:0] cnt;
  logic             initiate_seen;
  logic             start;
  logic             last;

  // timing initiate: select and initiate together, rising edge only
  assign start = pins.cycle_initiate_in && pins.memory_select_in &&
                 !initiate_seen && state == ST_IDLE && switch_enable;
  assign last  = state == ST_ACTIVE && cnt == CNT_W'(CYCLE_CYC - 1);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      initiate_seen <= 1'b0;
    end else begin
      initiate_seen <= pins.cycle_initiate_in && pins.memory_select_in;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          cnt <= '0;
          if (start) begin
            state <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          cnt <= cnt + CNT_W'(1);
          if (last) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      timing_initiate_pulse <= 1'b0;
    end else begin
      timing_initiate_pulse <= start;
    end
  end

  // ****************************************************************
  // cycle qualifiers, taken at the timing initiate
  // ****************************************************************
  logic          is_write;
  logic          xfer;
  write_source_t source;
  logic [1:0]    route_now;
  write_source_t next_source;

  assign route_now = {!pins.route_select_a_n, !pins.route_select_b_n};

  always_comb begin
    unique case (route_now)
      ROUTE_CU: next_source = SRC_CU;
      ROUTE_IO: next_source = SRC_IO;
      ROUTE_PE: next_source = SRC_PE;
      ROUTE_CB: next_source = SRC_NONE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      is_write <= 1'b0;
      xfer     <= 1'b0;
      source   <= SRC_NONE;
    end else if (start) begin
      is_write <= pins.read_write_select_n;
      xfer     <= transfer_active;
      source   <= pins.read_write_select_n ? next_source : SRC_NONE;
    end else if (last) begin
      is_write <= 1'b0;
      source   <= SRC_NONE;
    end
  end

  // ****************************************************************
  // half-select latches
  // ****************************************************************
  logic outer_half_latch;
  logic inner_half_latch;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      outer_half_latch <= 1'b0;
      inner_half_latch <= 1'b0;
    end else if (start && pins.read_write_select_n && next_source == SRC_PE) begin
      outer_half_latch <= !pins.outer_half_sel_n;
      inner_half_latch <= !pins.inner_half_sel_n;
    end else if (start && pins.read_write_select_n && next_source == SRC_CU) begin
      // full words from the control unit open both halves of the shared path
      outer_half_latch <= 1'b1;
      inner_half_latch <= 1'b1;
    end else if (last) begin
      outer_half_latch <= 1'b0;
      inner_half_latch <= 1'b0;
    end
  end

  // ****************************************************************
  // memory protect
  // ****************************************************************
  logic write_permit;
  logic protect_hit;

  assign protect_hit = start && pins.read_write_select_n &&
                       !pins.low_region_protect_n && &pins.address_hi_n;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      write_permit <= 1'b1;
    end else if (protect_hit) begin
      write_permit <= 1'b0;
    end else if (last) begin
      write_permit <= 1'b1;
    end
  end

  // status only; a new violation wins over a clear in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      protect_error <= 1'b0;
    end else if (protect_hit) begin
      protect_error <= 1'b1;
    end else if (!pins.protect_error_clear_n || sw_clear) begin
      protect_error <= 1'b0;
    end
  end

  // ****************************************************************
  // source select gates and holding latches
  // ****************************************************************
  logic [63:0] gate_mask;
  logic [63:0] select_inv;
  logic [63:0] latched_write_bits;

  always_comb begin
    io_write_select      = source == SRC_IO && is_write && !xfer;
    element_write_select = (source == SRC_PE || source == SRC_CU) && !xfer;
  end

  // element data passes per half; I/O data passes whole and ungated
  assign gate_mask = ({64{element_write_select && outer_half_latch}} & OUTER_MASK) |
                     ({64{element_write_select && inner_half_latch}} & INNER_MASK);
  assign select_inv = io_write_select ? ~io_bits : ~(elem_bits & gate_mask);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      capture_strobe_pulse <= '0;
    end else begin
      capture_strobe_pulse <= {BYTES{state == ST_ACTIVE && is_write &&
                                     cnt == CNT_W'(CAPTURE_CYC - 1)}};
    end
  end

  for (genvar b = 0; b < BYTES; b++) begin : g_slice
    always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
        latched_write_bits[8*b +: 8] <= '1;
      end else if (capture_strobe_pulse[b]) begin
        latched_write_bits[8*b +: 8] <= select_inv[8*b +: 8];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_out.write_word <= '0;
    end else begin
      mem_out.write_word <= ~latched_write_bits;
    end
  end

  // ****************************************************************
  // initiate and write enables
  // ****************************************************************
  logic write_go_due;
  logic read_go_due;
  logic write_go;
  logic [CNT_W-1:0] enable_left;

  // writes wait for the protect check; reads go straight after the initiate
  assign write_go_due = state == ST_ACTIVE && is_write &&
                        cnt == CNT_W'(WRITE_INIT_CYC - 1);
  assign read_go_due  = timing_initiate_pulse && !is_write;
  assign write_go     = write_go_due && write_permit && !xfer;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      delayed_write_go <= 1'b0;
    end else begin
      delayed_write_go <= write_go_due;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_out.memory_go_pulse_n <= 1'b1;
    end else begin
      mem_out.memory_go_pulse_n <= !(write_go || read_go_due);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      enable_left <= '0;
    end else if (write_go) begin
      enable_left <= CNT_W'(ENABLE_CYC);
    end else if (enable_left != '0) begin
      enable_left <= enable_left - CNT_W'(1);
    end
  end

  // enables stand from the go pulse for the enable window; a protect hit never opens it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mem_out.outer_half_write_en <= 1'b0;
      mem_out.inner_half_write_en <= 1'b0;
    end else if (write_go || (enable_left > CNT_W'(1) && write_permit)) begin
      mem_out.outer_half_write_en <= source == SRC_CU || source == SRC_IO ||
                                     (source == SRC_PE && outer_half_latch);
      mem_out.inner_half_write_en <= source == SRC_CU || source == SRC_IO ||
                                     (source == SRC_PE && inner_half_latch);
    end else begin
      mem_out.outer_half_write_en <= 1'b0;
      mem_out.inner_half_write_en <= 1'b0;
    end
  end
  // both enables high together store all 64 bits at once

  // ****************************************************************
  // register read
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= '0;
    end else if (reg_read && reg_addr == ADDR_CTRL) begin
      reg_rdata <= {31'h0, switch_enable};
    end else if (reg_read && reg_addr == ADDR_STATUS) begin
      reg_rdata <= {26'h0, source, write_permit, outer_half_latch,
                    inner_half_latch, protect_error};
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : memory_write_cycle_switch

`default_nettype wire

// [tb/write_switch_chk.sv]
// port checker for the memory write-cycle switch
// assumes one ref_clk domain; bound into every instance of the top module
`timescale 1ns/100ps
`default_nettype none
module write_switch_chk
  import mem_write_switch_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire ctrl_pins_t  ctrl_pins,
  input wire logic [63:0] io_write_bits,
  input wire logic        transfer_active,
  input wire mem_out_t    mem_out,
  input wire logic        timing_initiate_pulse,
  input wire logic        delayed_write_go,
  input wire logic        io_write_select,
  input wire logic        element_write_select,
  input wire logic [7:0]  capture_strobe_pulse,
  input wire logic        protect_error
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_wr_start;
    timing_initiate_pulse && ctrl_pins.read_write_select_n;
  endsequence
  sequence s_hit;
    s_wr_start ##0 (!ctrl_pins.low_region_protect_n && &ctrl_pins.address_hi_n);
  endsequence
  property p_go_cause;
    !mem_out.memory_go_pulse_n |->
      (ctrl_pins.read_write_select_n ? $past(timing_initiate_pulse, 2)
                                     : $past(timing_initiate_pulse));
  endproperty
  property p_go_short;
    !mem_out.memory_go_pulse_n |=> mem_out.memory_go_pulse_n;
  endproperty
  property p_wr_go;
    !mem_out.memory_go_pulse_n && ctrl_pins.read_write_select_n |->
      delayed_write_go && !transfer_active;
  endproperty
  property p_dwg;
    delayed_write_go |-> $past(timing_initiate_pulse, 2) && ctrl_pins.read_write_select_n;
  endproperty
  property p_hit;
    s_hit |=> (mem_out.memory_go_pulse_n && !mem_out.outer_half_write_en
               && !mem_out.inner_half_write_en) [*3];
  endproperty
  property p_err;
    s_hit |-> ##[1:4] protect_error;
  endproperty
  property p_full;
    s_wr_start ##0 (ctrl_pins.route_select_b_n && !transfer_active
                    && ctrl_pins.low_region_protect_n) |-> ##2
      mem_out.outer_half_write_en && mem_out.inner_half_write_en;
  endproperty
  property p_en_len;
    $rose(mem_out.outer_half_write_en) |->
      mem_out.outer_half_write_en [*3] ##1 !mem_out.outer_half_write_en;
  endproperty
  property p_io_sel;
    io_write_select |-> !ctrl_pins.route_select_a_n && ctrl_pins.route_select_b_n
      && ctrl_pins.read_write_select_n && !transfer_active && !element_write_select;
  endproperty
  property p_io_word;
    s_wr_start ##0 io_write_select |-> ##3 mem_out.write_word == io_write_bits;
  endproperty
  property p_cap;
    |capture_strobe_pulse |-> capture_strobe_pulse == 8'hff &&
      $past(timing_initiate_pulse) && ctrl_pins.read_write_select_n;
  endproperty
  a_go_cause: assert property (p_go_cause) else $error("go without initiate");
  a_go_short: assert property (p_go_short) else $error("go too long");
  a_wr_go: assert property (p_wr_go) else $error("write go unqualified");
  a_dwg: assert property (p_dwg) else $error("delayed go misplaced");
  a_hit: assert property (p_hit) else $error("protect hit not blocked");
  a_err: assert property (p_err) else $error("protect error not set");
  a_full: assert property (p_full) else $error("enables not forced");
  a_en_len: assert property (p_en_len) else $error("enable length wrong");
  a_io_sel: assert property (p_io_sel) else $error("io select wrong");
  a_io_word: assert property (p_io_word) else $error("io word wrong");
  a_cap: assert property (p_cap) else $error("capture strobe wrong");
endmodule : write_switch_chk

bind memory_write_cycle_switch write_switch_chk u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .ctrl_pins(ctrl_pins), .io_write_bits(io_write_bits),
  .transfer_active(transfer_active), .mem_out(mem_out),
  .timing_initiate_pulse(timing_initiate_pulse), .delayed_write_go(delayed_write_go),
  .io_write_select(io_write_select), .element_write_select(element_write_select),
  .capture_strobe_pulse(capture_strobe_pulse), .protect_error(protect_error));
`default_nettype wire

// [tb/pe_side_model.sv]
// element / control unit / io side: forms pin levels and runs one memory cycle
// assumes start is a one-cycle pulse from the bench
`timescale 1ns/100ps
`default_nettype none
module pe_side_model
  import mem_write_switch_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [1:0]  route,
  input  wire logic [1:0]  halves,
  input  wire logic        protect,
  input  wire logic [3:0]  addr,
  input  wire logic        clear_n,
  input  wire logic [63:0] pe_data,
  input  wire logic [63:0] io_data,
  output ctrl_pins_t       ctrl_pins,
  output logic [63:0]      element_write_bits,
  output logic [63:0]      io_write_bits,
  output logic             busy
);
  // ****************************************************************
  // cycle sequencing
  // ****************************************************************
  int cnt = 0;
  initial begin
    ctrl_pins = '0;
    element_write_bits = '0;
    io_write_bits = '0;
    busy = 1'b0;
  end
  always @(posedge ref_clk) begin
    ctrl_pins.protect_error_clear_n <= clear_n;
    if (start) begin
      ctrl_pins.cycle_initiate_in <= 1'b1;
      ctrl_pins.memory_select_in <= 1'b1;
      ctrl_pins.read_write_select_n <= is_write;
      ctrl_pins.route_select_a_n <= ~route[1];
      ctrl_pins.route_select_b_n <= ~route[0];
      ctrl_pins.outer_half_sel_n <= ~halves[1];
      ctrl_pins.inner_half_sel_n <= ~halves[0];
      ctrl_pins.low_region_protect_n <= ~protect;
      ctrl_pins.address_hi_n <= ~addr;
      element_write_bits <= pe_data;
      io_write_bits <= io_data;
      busy <= 1'b1;
      cnt <= 14;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 4) begin
        ctrl_pins.cycle_initiate_in <= 1'b0;
        ctrl_pins.memory_select_in <= 1'b0;
      end
      if (cnt == 1) begin
        // released data lines show no stale word
        busy <= 1'b0;
        element_write_bits <= ~element_write_bits;
        io_write_bits <= ~io_write_bits;
      end
    end
  end
endmodule : pe_side_model
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the memory write-cycle switch
// assumes the checker is bound in and the partner model drives the pins
`timescale 1ns/100ps
`default_nettype none
module testbench
  import mem_write_switch_pkg::*;
;
  // ****************************************************************
  // stimulus and checking
  // ****************************************************************
  logic        ref_clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic        transfer_active = 1'b0, start = 1'b0, is_write = 1'b0;
  logic        protect = 1'b0, clear_n = 1'b1, tip, dwg, io_sel, esel, busy, protect_error;
  logic [1:0]  route = '0, halves = '0;
  logic [3:0]  addr = '0, reg_addr = '0;
  logic [7:0]  cap;
  logic [31:0] reg_wdata = '0, reg_rdata, rv;
  logic [63:0] pe_data = '0, io_data = '0, element_write_bits, io_write_bits;
  ctrl_pins_t  ctrl_pins;
  mem_out_t    mem_out;
  int          err_total = 0, num_checks = 0, seed = 9;
  always #20 ref_clk = ~ref_clk;
  memory_write_cycle_switch uut (.ref_clk(ref_clk), .resetn(resetn), .ctrl_pins(ctrl_pins),
    .element_write_bits(element_write_bits), .io_write_bits(io_write_bits),
    .transfer_active(transfer_active), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .mem_out(mem_out),
    .timing_initiate_pulse(tip), .delayed_write_go(dwg), .io_write_select(io_sel),
    .element_write_select(esel), .capture_strobe_pulse(cap), .protect_error(protect_error));
  pe_side_model model (.ref_clk(ref_clk), .start(start), .is_write(is_write), .route(route),
    .halves(halves), .protect(protect), .addr(addr), .clear_n(clear_n), .pe_data(pe_data),
    .io_data(io_data), .ctrl_pins(ctrl_pins), .element_write_bits(element_write_bits),
    .io_write_bits(io_write_bits), .busy(busy));
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic cyc(input logic w, input logic [1:0] rt, input logic [1:0] hv,
                     input logic pr, input logic [3:0] ad, input logic xf, input logic en);
    logic        go;
    logic [63:0] m, d;
    int          n;
    @(posedge ref_clk);
    pe_data <= {$random(seed), $random(seed)};
    io_data <= {$random(seed), $random(seed)};
    is_write <= w;
    route <= rt;
    halves <= hv;
    protect <= pr;
    addr <= ad;
    transfer_active <= xf;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    go = !w || (!xf && !(pr && ad == 4'h0));
    m = (rt == ROUTE_PE) ? (({64{hv[1]}} & OUTER_MASK) | ({64{hv[0]}} & INNER_MASK)) : '1;
    m = (w && go && rt != ROUTE_CB) ? m : 64'h0;
    d = (rt == ROUTE_IO) ? io_data : pe_data;
    n = 0;
    while (tip !== 1'b1 && n < 10) begin
      @(negedge ref_clk);
      n++;
    end
    chk("initiate", tip, en);
    if (en) begin
      chk("io_select", io_sel, w && rt == ROUTE_IO && !xf);
      chk("elem_select", esel, w && (rt == ROUTE_PE || rt == ROUTE_CU) && !xf);
      @(negedge ref_clk);
      chk("capture", cap, w ? 8'hff : 8'h00);
      // writes wait one more cycle for the protect check
      repeat (w) @(negedge ref_clk);
      chk("go_n", mem_out.memory_go_pulse_n, !go);
      chk("delayed_go", dwg, w);
      chk("outer_en", mem_out.outer_half_write_en, |(m & OUTER_MASK));
      chk("inner_en", mem_out.inner_half_write_en, |(m & INNER_MASK));
      @(negedge ref_clk);
      chk("word", mem_out.write_word & m, d & m);
    end
    n = 0;
    while (busy && n < 30) begin
      @(negedge ref_clk);
      n++;
    end
    chk("busy", busy, 1'b0);
    @(posedge ref_clk);
    transfer_active <= 1'b0;
    repeat (3) @(posedge ref_clk);
    $display("cycle test done write %0d route %0d", w, rt);
  endtask : cyc
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    results();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(ADDR_CTRL, rv);
    chk("ctrl", rv, 32'h1);
    rd(ADDR_STATUS, rv);
    chk("status", rv, 32'h8);
    rd(4'h7, rv);
    chk("unmapped", rv, 32'h0);
    cyc(1, ROUTE_PE, 2'b11, 0, 4'h5, 0, 1);
    rd(ADDR_STATUS, rv);
    chk("latches", rv & 32'h6, 32'h0);
    cyc(1, ROUTE_PE, 2'b10, 0, 4'h3, 0, 1);
    cyc(1, ROUTE_PE, 2'b01, 0, 4'h3, 0, 1);
    cyc(1, ROUTE_CU, 2'b00, 0, 4'h2, 0, 1);
    cyc(1, ROUTE_IO, 2'b00, 0, 4'h2, 0, 1);
    cyc(1, ROUTE_CB, 2'b11, 0, 4'h2, 0, 1);
    cyc(1, ROUTE_IO, 2'b11, 0, 4'h2, 1, 1);
    cyc(0, ROUTE_PE, 2'b11, 1, 4'h0, 0, 1);
    cyc(1, ROUTE_PE, 2'b11, 1, 4'h1, 0, 1);
    cyc(1, ROUTE_PE, 2'b11, 1, 4'h0, 0, 1);
    rd(ADDR_STATUS, rv);
    chk("error_status", rv & 32'h9, 32'h9);
    @(posedge ref_clk);
    clear_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    clear_n <= 1'b1;
    chk("pin_clear", protect_error, 1'b0);
    cyc(1, ROUTE_IO, 2'b00, 1, 4'h0, 0, 1);
    wr(ADDR_CTRL, 32'h3);
    repeat (2) @(negedge ref_clk);
    chk("reg_clear", protect_error, 1'b0);
    wr(ADDR_CTRL, 32'h0);
    cyc(1, ROUTE_PE, 2'b11, 0, 4'h2, 0, 0);
    wr(ADDR_CTRL, 32'h1);
    repeat (4) cyc(1, 2'($random(seed)), 2'($random(seed)), 0, 4'h9, 0, 1);
    results();
  end
endmodule : testbench
`default_nettype wire
